// >>> logic/hpc_device.sv
// Device end of the host port: control register with host and CPU views,
// doorbells both ways, ready flag, fetch strobe, halfword assembly.
// Assumes the memory side reports a pending data access on mem_busy.
//
// Behaviour
// - Reserved control bits always read zero.
// - Fetch request field always reads zero.
// - Host fetch write starts fetch, not stored.
// - Ready field shows pending access, ignores select.
// - Interrupt pin is inverse of its field.
// - Host one sets core doorbell, rising edge.
// - CPU one on clear doorbell does nothing.
// - CPU one on set doorbell clears it.
// - Zero writes never change core doorbell.
// - CPU one sets host doorbell.
// - Host one clears host doorbell.
// - Zero writes never change host doorbell.
// - Order field sets narrow halfword significance.
// - Only the host may change order field.
// - Host programs order before data access.
// - Wide mode ignores the order field.
// - Writers send zero in reserved bits.
// - Ready drops while a data access pends.
// - Handshaked read polls, fetches, polls, reads.
// - After read, loop to poll, fetch or address.
// - Handshaked write polls before each data write.
// - Narrow halves of a read may differ.
`timescale 1ns/1ps
`default_nettype none
module hpc_device (
    input wire logic clk,
    input wire logic rstn,
    hpc_link_if.dev link,
    input wire logic narrow_host_mode,
    input wire logic cpu_we,
    input wire logic [15:0] cpu_wdata,
    output logic [31:0] cpu_rdata,
    output logic host_to_core_irq,
    output logic halfword_order,
    output logic fetch_req,
    input wire logic mem_busy,
    output logic xfer_valid,
    output logic xfer_is_addr,
    output logic [31:0] xfer_word,
    input wire logic [31:0] addr_word,
    input wire logic [31:0] data_word
);
    logic order_ff;
    logic h2c_ff;
    logic c2h_ff;
    logic rdy_ff;
    logic fetch_ff;
    logic irq_n_ff;
    logic [31:0] rdata_ff;
    logic [31:0] cpu_rdata_ff;
    logic [15:0] first_ff;
    logic xfer_valid_ff;
    logic xfer_is_addr_ff;
    logic [31:0] xfer_word_ff;
    logic host_ctrl_wr;
    logic host_word_wr;
    logic nxt_fetch;
    logic nxt_data_start;
    logic nxt_h2c;
    logic nxt_c2h;
    logic [15:0] view;
    logic [15:0] hw;
    logic [31:0] rd_word;
    logic [31:0] nxt_word;
    logic word_done;

    // Narrow mode places each halfword on the low lanes of the link
    assign hw = link.wdata[15:0];
    assign host_ctrl_wr = link.cs && link.we && (link.sel == hpc_pkg::SEL_CTRL);
    assign host_word_wr = link.cs && link.we && (link.sel != hpc_pkg::SEL_CTRL);
    assign nxt_fetch = host_ctrl_wr && hw[hpc_pkg::FLD_FETCH];
    assign word_done = host_word_wr && (!narrow_host_mode || link.half);
    assign nxt_data_start = word_done && (link.sel == hpc_pkg::SEL_DATA);

    // host sets, CPU clears set bit
    always_comb begin
        nxt_h2c = h2c_ff;
        // zero or clear-state CPU writes are no-ops
        if (cpu_we && cpu_wdata[hpc_pkg::FLD_H2C] && h2c_ff) begin
            nxt_h2c = 1'b0;
        end
        // Set wins over a clear in the same cycle
        if (host_ctrl_wr && hw[hpc_pkg::FLD_H2C]) begin
            nxt_h2c = 1'b1;
        end
    end

    // host one clears, CPU one sets
    always_comb begin
        nxt_c2h = c2h_ff;
        // zero writes leave the bit alone
        if (host_ctrl_wr && hw[hpc_pkg::FLD_C2H]) begin
            nxt_c2h = 1'b0;
        end
        if (cpu_we && cpu_wdata[hpc_pkg::FLD_C2H]) begin
            nxt_c2h = 1'b1;
        end
    end

    // reserved and fetch positions are constant zero
    assign view = {11'h000, 1'b0, rdy_ff, c2h_ff, h2c_ff, order_ff};

    // first halfword high when order is zero
    always_comb begin
        if (!narrow_host_mode) begin
            nxt_word = link.wdata;
        end else if (order_ff) begin
            nxt_word = {hw, first_ff};
        end else begin
            nxt_word = {first_ff, hw};
        end
    end

    always_comb begin
        rd_word = data_word;
        if (link.sel == hpc_pkg::SEL_ADDR) begin
            rd_word = addr_word;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            h2c_ff <= hpc_pkg::RST_H2C;
            c2h_ff <= hpc_pkg::RST_C2H;
        end else begin
            h2c_ff <= nxt_h2c;
            c2h_ff <= nxt_c2h;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            order_ff <= hpc_pkg::RST_ORDER;
        end else if (host_ctrl_wr) begin
            // no CPU path into this bit
            order_ff <= hw[hpc_pkg::FLD_ORDER];
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irq_n_ff <= 1'b1;
        end else begin
            irq_n_ff <= !nxt_c2h;
        end
    end

    // ready low while a fetch or data access pends
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdy_ff <= hpc_pkg::RST_RDY;
        end else begin
            rdy_ff <= !(mem_busy || nxt_fetch || nxt_data_start);
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            fetch_ff <= 1'b0;
        end else begin
            fetch_ff <= nxt_fetch;
        end
    end

    // First halfword of a narrow transfer waits for its partner
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            first_ff <= 16'h0000;
        end else if (host_word_wr && !link.half) begin
            first_ff <= hw;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            xfer_valid_ff <= 1'b0;
            xfer_is_addr_ff <= 1'b0;
            xfer_word_ff <= 32'h0000_0000;
        end else begin
            xfer_valid_ff <= word_done;
            if (word_done) begin
                xfer_is_addr_ff <= (link.sel == hpc_pkg::SEL_ADDR);
                xfer_word_ff <= nxt_word;
            end
        end
    end

    // Host read answer, one cycle after the strobe
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata_ff <= 32'h0000_0000;
        end else if (link.cs && link.re) begin
            if (link.sel == hpc_pkg::SEL_CTRL) begin
                // each halfword read samples the field afresh
                rdata_ff <= narrow_host_mode ? {16'h0000, view} : {view, view};
            end else if (!narrow_host_mode) begin
                rdata_ff <= rd_word;
            end else if (link.half != order_ff) begin
                // second half with order zero is the low half
                rdata_ff <= {16'h0000, rd_word[15:0]};
            end else begin
                rdata_ff <= {16'h0000, rd_word[31:16]};
            end
        end
    end

    // CPU view: upper halfword reserved
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cpu_rdata_ff <= 32'h0000_0000;
        end else begin
            cpu_rdata_ff <= {16'h0000, view};
        end
    end

    assign link.rdata = rdata_ff;
    assign link.rdy = rdy_ff;
    assign link.irq_n = irq_n_ff;
    assign cpu_rdata = cpu_rdata_ff;
    assign host_to_core_irq = h2c_ff;
    assign halfword_order = order_ff;
    assign fetch_req = fetch_ff;
    assign xfer_valid = xfer_valid_ff;
    assign xfer_is_addr = xfer_is_addr_ff;
    assign xfer_word = xfer_word_ff;
endmodule // hpc_device
`default_nettype wire

// >>> logic/hpc_host.sv
// Host end of the host port: an AXI4-Lite slave taking link commands from
// software and running one link access per command.
// Assumes the device answers a read one cycle after the strobe.
`timescale 1ns/1ps
`default_nettype none
module hpc_host (
    input wire logic clk,
    input wire logic rstn,
    hpc_link_if.host link,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    hpc_pkg::hpc_hstate_type state_ff;
    logic have_aw_ff, have_w_ff, awready_ff, wready_ff, bvalid_ff;
    logic arready_ff, rvalid_ff;
    logic [1:0] bresp_ff, rresp_ff;
    logic [3:0] awaddr_ff;
    logic [31:0] wbuf_ff, axi_rdata_ff, wreg_ff, cmd_ff, rdreg_ff;
    logic refused_ff, order_set_ff;
    logic cs_ff, we_ff, re_ff, half_ff;
    logic [1:0] sel_ff;
    logic [31:0] lwdata_ff;
    logic nxt_have_aw, nxt_have_w, nxt_bvalid, nxt_rvalid, wr_fire, launch;
    logic refuse;
    logic [1:0] csel;
    logic [31:0] stat;

    assign nxt_have_aw = (have_aw_ff || (s_axi_awvalid && awready_ff)) &&
        !wr_fire;
    assign nxt_have_w = (have_w_ff || (s_axi_wvalid && wready_ff)) && !wr_fire;
    assign wr_fire = have_aw_ff && have_w_ff && !bvalid_ff;
    assign nxt_bvalid = wr_fire || (bvalid_ff && !s_axi_bready);
    assign nxt_rvalid = (s_axi_arvalid && arready_ff) ||
        (rvalid_ff && !s_axi_rready);
    assign launch = wr_fire && (awaddr_ff == hpc_pkg::OFS_CMD);
    assign csel = wbuf_ff[hpc_pkg::CMD_SEL_LSB +: 2];
    // no data or address access before order is set
    // data access only while ready reads one
    assign refuse = (state_ff != hpc_pkg::HST_IDLE) ||
        (csel != hpc_pkg::SEL_CTRL && !order_set_ff) ||
        (csel == hpc_pkg::SEL_DATA && !link.rdy);
    assign stat = {27'h0000000, order_set_ff, !link.irq_n, link.rdy,
        refused_ff, state_ff != hpc_pkg::HST_IDLE};

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            have_aw_ff <= 1'b0;
            have_w_ff <= 1'b0;
            awready_ff <= 1'b0;
            wready_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= hpc_pkg::RESP_OKAY;
            awaddr_ff <= 4'h0;
            wbuf_ff <= 32'h0000_0000;
        end else begin
            have_aw_ff <= nxt_have_aw;
            have_w_ff <= nxt_have_w;
            awready_ff <= !nxt_have_aw && !nxt_bvalid;
            wready_ff <= !nxt_have_w && !nxt_bvalid;
            bvalid_ff <= nxt_bvalid;
            if (s_axi_awvalid && awready_ff) begin
                awaddr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && wready_ff) begin
                wbuf_ff <= s_axi_wdata;
            end
            if (wr_fire) begin
                bresp_ff <= (awaddr_ff == hpc_pkg::OFS_CMD ||
                    awaddr_ff == hpc_pkg::OFS_WDATA) ?
                    hpc_pkg::RESP_OKAY : hpc_pkg::RESP_SLVERR;
            end
        end
    end

    // Software registers; byte strobes are not honoured, whole words only
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wreg_ff <= 32'h0000_0000;
            cmd_ff <= 32'h0000_0000;
            refused_ff <= 1'b0;
        end else if (wr_fire) begin
            if (awaddr_ff == hpc_pkg::OFS_WDATA) begin
                wreg_ff <= wbuf_ff;
            end
            if (launch) begin
                // A refused launch must not disturb the access in flight
                if (!refuse) begin
                    cmd_ff <= wbuf_ff;
                end
                refused_ff <= refuse;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b0;
            rresp_ff <= hpc_pkg::RESP_OKAY;
            axi_rdata_ff <= 32'h0000_0000;
        end else begin
            arready_ff <= !nxt_rvalid;
            rvalid_ff <= nxt_rvalid;
            if (s_axi_arvalid && arready_ff) begin
                rresp_ff <= hpc_pkg::RESP_OKAY;
                unique case (s_axi_araddr)
                    hpc_pkg::OFS_CMD: axi_rdata_ff <= cmd_ff;
                    hpc_pkg::OFS_WDATA: axi_rdata_ff <= wreg_ff;
                    hpc_pkg::OFS_STAT: axi_rdata_ff <= stat;
                    hpc_pkg::OFS_RDATA: axi_rdata_ff <= rdreg_ff;
                    default: begin
                        axi_rdata_ff <= 32'h0000_0000;
                        rresp_ff <= hpc_pkg::RESP_SLVERR;
                    end
                endcase
            end
        end
    end

    // each command is one step; software chains poll, fetch, address
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_ff <= hpc_pkg::HST_IDLE;
            cs_ff <= 1'b0;
            we_ff <= 1'b0;
            re_ff <= 1'b0;
            sel_ff <= hpc_pkg::SEL_CTRL;
            half_ff <= 1'b0;
            lwdata_ff <= 32'h0000_0000;
            rdreg_ff <= 32'h0000_0000;
            order_set_ff <= 1'b0;
        end else begin
            unique case (state_ff)
                hpc_pkg::HST_IDLE: begin
                    if (launch && !refuse) begin
                        state_ff <= hpc_pkg::HST_STROBE;
                        cs_ff <= 1'b1;
                        we_ff <= wbuf_ff[hpc_pkg::CMD_WRITE];
                        re_ff <= !wbuf_ff[hpc_pkg::CMD_WRITE];
                        sel_ff <= csel;
                        half_ff <= wbuf_ff[hpc_pkg::CMD_HALF];
                        // reserved control bits go out as zero
                        lwdata_ff <= (csel == hpc_pkg::SEL_CTRL) ?
                            {wreg_ff[31:16] & hpc_pkg::CTRL_WMASK,
                             wreg_ff[15:0] & hpc_pkg::CTRL_WMASK} : wreg_ff;
                        if (csel == hpc_pkg::SEL_CTRL &&
                            wbuf_ff[hpc_pkg::CMD_WRITE]) begin
                            order_set_ff <= 1'b1;
                        end
                    end
                end
                hpc_pkg::HST_STROBE: begin
                    state_ff <= hpc_pkg::HST_CAPTURE;
                    cs_ff <= 1'b0;
                    we_ff <= 1'b0;
                    re_ff <= 1'b0;
                end
                hpc_pkg::HST_CAPTURE: begin
                    state_ff <= hpc_pkg::HST_IDLE;
                    if (!cmd_ff[hpc_pkg::CMD_WRITE]) begin
                        rdreg_ff <= link.rdata;
                    end
                end
            endcase
        end
    end

    assign link.cs = cs_ff;
    assign link.we = we_ff;
    assign link.re = re_ff;
    assign link.sel = sel_ff;
    assign link.half = half_ff;
    assign link.wdata = lwdata_ff;
    assign s_axi_awready = awready_ff;
    assign s_axi_wready = wready_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rdata = axi_rdata_ff;
    assign s_axi_rresp = rresp_ff;
    assign s_axi_rvalid = rvalid_ff;
endmodule // hpc_host
`default_nettype wire

// >>> logic/hpc_link_if.sv
// Parallel host port link between the host end and the device end.
// Both ends sit on the same clock; strobes are one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
interface hpc_link_if (
    input wire logic clk
);
    logic cs;
    logic we;
    logic re;
    logic [1:0] sel;
    logic half;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic rdy;
    logic irq_n;
    modport host (
        output cs, we, re, sel, half, wdata,
        input rdata, rdy, irq_n
    );
    modport dev (
        input cs, we, re, sel, half, wdata,
        output rdata, rdy, irq_n
    );
endinterface
`default_nettype wire

// >>> logic/hpc_pkg.sv
// Shared constants of the host port control block: link register selects,
// control field positions, reset values and the host end's register map.
// Assumes both ends run on one clock and one reset.
package hpc_pkg;
    localparam int HALF_W = 16;
    // Link register selects
    localparam logic [1:0] SEL_CTRL = 2'h0;
    localparam logic [1:0] SEL_ADDR = 2'h1;
    localparam logic [1:0] SEL_DATA = 2'h2;
    // Control field positions inside one halfword
    localparam int FLD_ORDER = 0;
    localparam int FLD_H2C = 1;
    localparam int FLD_C2H = 2;
    localparam int FLD_RDY = 3;
    localparam int FLD_FETCH = 4;
    // Reset values of the control fields
    localparam logic RST_ORDER = 1'b0;
    localparam logic RST_H2C = 1'b0;
    localparam logic RST_C2H = 1'b0;
    localparam logic RST_RDY = 1'b1;
    // Bits a writer may set; every other position is sent as zero
    localparam logic [15:0] CTRL_WMASK = 16'h0017;
    // Host end register map (byte addresses)
    localparam logic [3:0] OFS_CMD = 4'h0;
    localparam logic [3:0] OFS_WDATA = 4'h4;
    localparam logic [3:0] OFS_STAT = 4'h8;
    localparam logic [3:0] OFS_RDATA = 4'hC;
    // Command register fields
    localparam int CMD_SEL_LSB = 0;
    localparam int CMD_WRITE = 2;
    localparam int CMD_HALF = 3;
    // Status register fields
    localparam int ST_BUSY = 0;
    localparam int ST_REFUSED = 1;
    localparam int ST_READY = 2;
    localparam int ST_IRQ = 3;
    localparam int ST_ORDER_SET = 4;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {
        HST_IDLE,
        HST_STROBE,
        HST_CAPTURE
    } hpc_hstate_type;
endpackage

// >>> tb/hpc_link_properties.sv
// Checker on the host port link: properties over the link signals only.
// Assumes the device end runs in narrow host mode on the link clock.
`timescale 1ns/1ps
`default_nettype none
module hpc_link_properties (
    input wire logic clk,
    input wire logic rstn,
    input wire logic cs,
    input wire logic we,
    input wire logic re,
    input wire logic [1:0] sel,
    input wire logic half,
    input wire logic [31:0] wdata,
    input wire logic [31:0] rdata,
    input wire logic rdy,
    input wire logic irq_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    logic ctrl_rd;
    logic ctrl_wr;
    assign ctrl_rd = cs && re && sel == hpc_pkg::SEL_CTRL;
    assign ctrl_wr = cs && we && sel == hpc_pkg::SEL_CTRL;
    reserved_zero_a:
        assert property (ctrl_rd |=> rdata[31:21] == 11'h000 && rdata[15:5] == 11'h000)
        else $error("reserved control bits read nonzero");
    fetch_reads_zero_a:
        assert property (ctrl_rd |=> !rdata[20] && !rdata[4])
        else $error("fetch field read nonzero");
    ready_field_a:
        assert property (ctrl_rd |=> rdata[3] == $past(rdy))
        else $error("ready field differs from ready pin");
    pin_inverse_a:
        assert property (ctrl_rd |=> rdata[2] == !$past(irq_n))
        else $error("interrupt pin not inverse of its field");
    host_clear_pin_a:
        assert property (ctrl_wr && wdata[2] |=> irq_n)
        else $error("host one did not release interrupt pin");
    zero_keeps_pin_a:
        assert property (ctrl_wr && !wdata[2] && !irq_n |=> !irq_n)
        else $error("host zero changed interrupt pin");
    fetch_drops_ready_a:
        assert property (ctrl_wr && wdata[4] |-> ##[1:2] !rdy)
        else $error("fetch did not drop ready");
    write_drops_ready_a:
        assert property (cs && we && sel == hpc_pkg::SEL_DATA && half |-> ##[1:2] !rdy)
        else $error("data write did not drop ready");
    data_needs_ready_a:
        assert property (cs && sel == hpc_pkg::SEL_DATA |-> rdy)
        else $error("data access while not ready");
    strobe_spacing_a:
        assert property (cs |=> !cs [*2])
        else $error("link strobes too close");
endmodule // hpc_link_properties
`default_nettype wire

// >>> tb/tb_top.sv
// Bench joining host end and device end over the link; drives AXI and CPU.
// Assumes narrow host mode save for one wide write; memory answers quickly.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin errors++; \
    $display("unexpected at %0t got %0h exp %0h", $time, (g), (e)); end end
module tb_top;
    logic clk, rstn, cpu_we, mem_busy, host_to_core_irq, halfword_order;
    logic fetch_req, xfer_valid, xfer_is_addr, narrow_host_mode;
    logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [3:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, cpu_rdata, xfer_word;
    logic [31:0] addr_word, data_word, d, w;
    logic [1:0] s_axi_bresp, s_axi_rresp, eb;
    logic [15:0] cpu_wdata;
    logic [65:0] er;
    logic [32:0] ex;
    logic [1:0] wr_q[$];
    logic [65:0] rd_q[$];
    logic [32:0] xf_q[$];
    int errors, check_count, fetch_seen, fetch_exp, mem_cnt;
    hpc_link_if link (.clk(clk));
    hpc_host hpc_host_inst (.clk, .rstn, .link(link), .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF),
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    hpc_device hpc_device_inst (.clk, .rstn, .link(link),
        .narrow_host_mode, .cpu_we, .cpu_wdata, .cpu_rdata,
        .host_to_core_irq, .halfword_order, .fetch_req, .mem_busy,
        .xfer_valid, .xfer_is_addr, .xfer_word, .addr_word, .data_word);
    hpc_link_properties chk_inst (.clk(clk), .rstn(rstn), .cs(link.cs),
        .we(link.we), .re(link.re), .sel(link.sel), .half(link.half),
        .wdata(link.wdata), .rdata(link.rdata), .rdy(link.rdy),
        .irq_n(link.irq_n));
    initial clk = 1'b0;
    always #5 clk = ~clk;
    // Memory side stays busy a random few cycles after each request
    always @(posedge clk) begin
        if (fetch_req || xfer_valid) mem_cnt <= 2 + $urandom % 4;
        else if (mem_cnt != 0) mem_cnt <= mem_cnt - 1;
    end
    // Busy already in the request cycle, so ready never blinks high
    assign mem_busy = mem_cnt != 0 || fetch_req || xfer_valid;
    always @(posedge clk) begin
        if (rstn) begin
            if (s_axi_bvalid && s_axi_bready) begin
                eb = wr_q.size() ? wr_q.pop_front() : 2'hX;
                `CHK(s_axi_bresp, eb)
            end
            if (s_axi_rvalid && s_axi_rready) begin
                er = rd_q.size() ? rd_q.pop_front() : {66{1'bX}};
                `CHK(s_axi_rresp, er[65:64])
                if (er[63:32] != 32'h0) `CHK(s_axi_rdata & er[63:32], er[31:0])
            end
            if (xfer_valid) begin
                ex = xf_q.size() ? xf_q.pop_front() : {33{1'bX}};
                `CHK({xfer_is_addr, xfer_word}, ex)
            end
            if (fetch_req) fetch_seen++;
        end
    end
    task end_of_test();
        $display("comparisons %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task hang();
        errors++;
        $display("unexpected hang at %0t got %0h exp %0h", $time, 0, 1);
        end_of_test();
    endtask
    task axi_wr(input logic [3:0] a, input logic [31:0] v,
                input logic [1:0] resp);
        int n;
        wr_q.push_back(resp);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!(s_axi_bvalid && s_axi_bready) && n < 200);
        s_axi_bready <= 1'b0;
        if (n >= 200) hang();
    endtask
    task axi_rd(input logic [3:0] a, input logic [31:0] m,
                input logic [31:0] e, input logic [1:0] resp);
        int n;
        rd_q.push_back({resp, m, e & m});
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!(s_axi_rvalid && s_axi_rready) && n < 200);
        d = s_axi_rdata;
        s_axi_rready <= 1'b0;
        if (n >= 200) hang();
    endtask
    task poll_rdy();
        int n;
        n = 0;
        do begin
            axi_rd(hpc_pkg::OFS_STAT, 32'h0, 32'h0, hpc_pkg::RESP_OKAY);
            n++;
        end while ((d[hpc_pkg::ST_BUSY] || !d[hpc_pkg::ST_READY]) && n < 50);
        if (d[hpc_pkg::ST_BUSY] || !d[hpc_pkg::ST_READY]) hang();
    endtask
    task lnk(input logic [1:0] s, input logic wr, input logic h,
             input logic [31:0] v);
        poll_rdy();
        if (wr) axi_wr(hpc_pkg::OFS_WDATA, v, hpc_pkg::RESP_OKAY);
        axi_wr(hpc_pkg::OFS_CMD, {28'h0000000, h, wr, s}, hpc_pkg::RESP_OKAY);
        poll_rdy();
    endtask
    task ctl_rd(input logic [15:0] e);
        lnk(hpc_pkg::SEL_CTRL, 1'b0, 1'b0, 32'h0);
        axi_rd(hpc_pkg::OFS_RDATA, 32'h0000FFFF, {16'h0000, e},
               hpc_pkg::RESP_OKAY);
    endtask
    task cpu_wr(input logic [15:0] v);
        @(posedge clk);
        cpu_we <= 1'b1;
        cpu_wdata <= v;
        @(posedge clk);
        cpu_we <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    function automatic logic [15:0] hw(logic [31:0] x, logic o, logic h);
        return (h ^ o) ? x[15:0] : x[31:16];
    endfunction
    initial begin
        rstn = 1'b0;
        narrow_host_mode = 1'b1;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 4'h0;
        {s_axi_rready, cpu_we, s_axi_awaddr, s_axi_araddr} = 10'h000;
        {s_axi_wdata, cpu_wdata, data_word, mem_cnt} = '0;
        void'($urandom(96));
        addr_word = $urandom;
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        repeat (2) @(posedge clk);
        `CHK(cpu_rdata, 32'h00000008)
        axi_rd(hpc_pkg::OFS_STAT, 32'h0000001F, 32'h4, 2'h0);
        ctl_rd(16'h0008);
        $display("test reset values done");
        axi_wr(hpc_pkg::OFS_STAT, 32'h1, hpc_pkg::RESP_SLVERR);
        axi_rd(4'h1, 32'hFFFFFFFF, 32'h0, hpc_pkg::RESP_SLVERR);
        lnk(hpc_pkg::SEL_DATA, 1'b1, 1'b0, 32'h1234);
        axi_rd(hpc_pkg::OFS_STAT, 32'h3, 32'h2, 2'h0);
        $display("test refusals done");
        lnk(hpc_pkg::SEL_CTRL, 1'b1, 1'b0, 32'hFFEBFFEB);
        `CHK({halfword_order, host_to_core_irq}, 2'h3)
        `CHK(cpu_rdata, 32'h0000000B)
        cpu_wr(16'h0000);
        `CHK({halfword_order, host_to_core_irq}, 2'h3)
        lnk(hpc_pkg::SEL_CTRL, 1'b1, 1'b0, 32'h1);
        `CHK(host_to_core_irq, 1'b1)
        cpu_wr(16'h0002);
        `CHK(host_to_core_irq, 1'b0)
        cpu_wr(16'h0002);
        `CHK(host_to_core_irq, 1'b0)
        cpu_wr(16'h0004);
        `CHK(link.irq_n, 1'b0)
        axi_rd(hpc_pkg::OFS_STAT, 32'h8, 32'h8, 2'h0);
        lnk(hpc_pkg::SEL_CTRL, 1'b1, 1'b0, 32'h1);
        ctl_rd(16'h000D);
        lnk(hpc_pkg::SEL_CTRL, 1'b1, 1'b0, 32'h5);
        `CHK(link.irq_n, 1'b1)
        $display("test doorbells done");
        for (int o = 0; o < 2; o++) begin
            lnk(hpc_pkg::SEL_CTRL, 1'b1, 1'b0, o);
            `CHK(halfword_order, o[0])
            for (int i = 0; i < 4; i++) begin
                w = $urandom;
                xf_q.push_back({i[0], w});
                for (int h = 0; h < 2; h++) begin
                    lnk({~i[0], i[0]}, 1'b1, h[0], hw(w, o[0], h[0]));
                end
            end
            w = $urandom;
            data_word <= w;
            fetch_exp++;
            lnk(hpc_pkg::SEL_CTRL, 1'b1, 1'b0, 32'h10 | o);
            ctl_rd(16'h0008 | o);
            for (int h = 0; h < 2; h++) begin
                lnk(hpc_pkg::SEL_DATA, 1'b0, h[0], 32'h0);
                axi_rd(hpc_pkg::OFS_RDATA, 32'hFFFF, hw(w, o[0], h[0]), 2'h0);
            end
        end
        // Wide strap with order still one: the word passes unswapped
        narrow_host_mode <= 1'b0;
        w = $urandom;
        xf_q.push_back({1'b0, w});
        lnk(hpc_pkg::SEL_DATA, 1'b1, 1'b0, w);
        $display("test halfword order and fetch done");
        `CHK(fetch_seen, fetch_exp)
        `CHK(xf_q.size(), 0)
        end_of_test();
    end
    initial begin
        repeat (100000) @(posedge clk);
        hang();
    end
endmodule // tb_top
`default_nettype wire
